// [design/dsp_misc_ops.sv]
// Overview of operation
// - Negate writes two's complement back
// - Negate updates carry, zero, overflow flags
// - Negate negative flag is overflow xor sign
// - Conditional negate acts only when condition set
// - Mask clears upper byte, top 16-imm bits
// - Mask sets zero, clears shift overflow, sign
// - Bit clear zeroes one selected flag bit
// - Remainder adds twice product when quotient sign
// - Round adds 800000h to wide accumulator
// - Remainder/round set per-accumulator guard overflow
// - Sticky guard overflow sets, otherwise holds
//
// Purpose: Misc accumulator ops of a 24-bit DSP datapath, APB driven
// Assumes: Single clock, synchronous reset, zero-wait APB writes
// Notes: Writing the command register executes one instruction
`timescale 1ns/1ps
module dsp_misc_ops (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [dsp_misc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [dsp_misc_pkg::DATA_W-1:0] pwdata_in,
  output logic [dsp_misc_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  import dsp_misc_pkg::*;

  // Byte offsets of general accumulators 1 to 3
  localparam logic [ADDR_W-1:0] ACC1_OFS = ACC0_OFS + ACC_STRIDE;
  localparam logic [ADDR_W-1:0] ACC2_OFS = ACC1_OFS + ACC_STRIDE;
  localparam logic [ADDR_W-1:0] ACC3_OFS = ACC2_OFS + ACC_STRIDE;

  logic [ACC_W-1:0] acc_reg [ACC_NUM];
  logic [SG_W-1:0] shift_guard_register_reg;
  logic [MAC_W-1:0] ma_reg [2];
  logic [PROD_W-1:0] prod_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic [DATA_W-1:0] prdata_reg;

  logic access;
  logic wr;
  logic mapped;
  logic exec;
  logic [DATA_W-1:0] rd_next;
  logic [3:0] op;
  logic [1:0] acc_sel;
  logic mac_sel;
  logic [3:0] imm;
  logic [3:0] bit_select_field;
  logic [2:0] acc_idx;

  assign access = psel_in & penable_in;
  assign wr = access & pwrite_in & mapped;
  assign exec = wr & (paddr_in == CMD_OFS);
  assign pready_out = access;
  // Unmapped addresses answer with an error and change nothing
  assign pslverr_out = access & ~mapped;
  assign prdata_out = prdata_reg;

  assign op = pwdata_in[CMD_OP_LSB +: 4];
  assign acc_sel = pwdata_in[CMD_ACC_LSB +: 2];
  assign mac_sel = pwdata_in[CMD_MAC_BIT];
  assign imm = pwdata_in[CMD_IMM_LSB +: 4];
  assign bit_select_field = pwdata_in[CMD_BS_LSB +: 4];

  // Negate datapath
  logic [ACC_W-1:0] neg_src;
  logic [ACC_W-1:0] neg_res;
  logic neg_carry;
  logic neg_ovf;
  logic neg_do;
  assign neg_src = acc_reg[acc_sel];
  assign {neg_carry, neg_res} = {1'b0, ~neg_src} +
                                {{ACC_W{1'b0}}, 1'b1};
  // Only the most negative value cannot be negated
  assign neg_ovf = (neg_src == ACC_MIN);
  assign neg_do = (op == OP_NEG) |
                  ((op == OP_CNEG) & flags_reg[F_COND]);

  // Mask datapath
  logic [SG_LOW_W-1:0] mask_pat;
  logic [SG_W-1:0] mask_res;
  // Keeps the low imm bits, so 16-imm top bits are cleared
  assign mask_pat = ~(SG_ONES << imm);
  assign mask_res = {{(SG_W-SG_LOW_W){1'b0}},
                     shift_guard_register_reg[SG_LOW_W-1:0] &
                     mask_pat};

  // Wide accumulator adder shared by restore and round
  logic [MAC_W-1:0] ma_src;
  logic [MAC_W-1:0] addend;
  logic [MAC_W:0] wide_sum;
  logic [MAC_W-1:0] ma_res;
  logic guard_ovf;
  logic sticky_ovf;
  assign ma_src = ma_reg[mac_sel];
  always_comb begin
    if (op == OP_ROUND) begin
      addend = ROUND_CONST;
    end else if (flags_reg[F_QSIGN]) begin
      addend = {{(MAC_W-PROD_W-1){prod_reg[PROD_W-1]}},
                prod_reg, 1'b0};
    end else begin
      addend = '0;
    end
  end
  assign wide_sum = {ma_src[MAC_W-1], ma_src} + {addend[MAC_W-1], addend};
  assign ma_res = wide_sum[MAC_W-1:0];
  // Result leaves the 48-bit signed range into the guard bits
  assign guard_ovf = ~((&ma_res[MAC_W-1:GUARD_LSB]) |
                       ~(|ma_res[MAC_W-1:GUARD_LSB]));
  // Guard bits themselves overflow: 52-bit signed overflow
  assign sticky_ovf = wide_sum[MAC_W] ^ wide_sum[MAC_W-1];

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_next = '0;
    acc_idx = 3'(({1'b0, paddr_in} - {1'b0, ACC0_OFS}) >> 2);
    case (paddr_in)
      CMD_OFS: rd_next = {{(DATA_W-CMD_W){1'b0}}, cmd_reg};
      FLAGS_OFS: rd_next = {{(DATA_W-FLAG_W){1'b0}}, flags_reg};
      ACC0_OFS, ACC1_OFS, ACC2_OFS, ACC3_OFS: begin
        rd_next = {{(DATA_W-ACC_W){1'b0}}, acc_reg[acc_idx[1:0]]};
      end
      SG_OFS: rd_next = {{(DATA_W-SG_W){1'b0}}, shift_guard_register_reg};
      MA0_LO_OFS: rd_next = ma_reg[0][DATA_W-1:0];
      MA0_HI_OFS: rd_next = {{(DATA_W-MAC_HI_W){1'b0}},
                             ma_reg[0][MAC_W-1:DATA_W]};
      MA1_LO_OFS: rd_next = ma_reg[1][DATA_W-1:0];
      MA1_HI_OFS: rd_next = {{(DATA_W-MAC_HI_W){1'b0}},
                             ma_reg[1][MAC_W-1:DATA_W]};
      P_LO_OFS: rd_next = prod_reg[DATA_W-1:0];
      P_HI_OFS: rd_next = {{(DATA_W-PROD_HI_W){1'b0}},
                           prod_reg[PROD_W-1:DATA_W]};
      default: mapped = 1'b0;
    endcase
  end

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_reg <= '0;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_reg <= rd_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmd_reg <= '0;
    end else if (exec) begin
      cmd_reg <= pwdata_in[CMD_W-1:0];
    end
  end

  // Idle op falls through every branch below untouched
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < ACC_NUM; i++) begin
        acc_reg[i] <= '0;
      end
    end else if (exec & neg_do) begin
      acc_reg[acc_sel] <= neg_res;
    end else if (wr & (paddr_in >= ACC0_OFS) &
                 (paddr_in <= ACC3_OFS)) begin
      acc_reg[acc_idx[1:0]] <= pwdata_in[ACC_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shift_guard_register_reg <= '0;
    end else if (exec & (op == OP_MASK)) begin
      shift_guard_register_reg <= mask_res;
    end else if (wr & (paddr_in == SG_OFS)) begin
      shift_guard_register_reg <= pwdata_in[SG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ma_reg[0] <= '0;
      ma_reg[1] <= '0;
    end else if (exec & ((op == OP_ROUND) | (op == OP_RESTORE))) begin
      ma_reg[mac_sel] <= ma_res;
    end else if (wr) begin
      case (paddr_in)
        MA0_LO_OFS: ma_reg[0][DATA_W-1:0] <= pwdata_in;
        MA0_HI_OFS: ma_reg[0][MAC_W-1:DATA_W] <= pwdata_in[MAC_HI_W-1:0];
        MA1_LO_OFS: ma_reg[1][DATA_W-1:0] <= pwdata_in;
        MA1_HI_OFS: ma_reg[1][MAC_W-1:DATA_W] <= pwdata_in[MAC_HI_W-1:0];
        default: ;
      endcase
    end
  end

  // Product register is loaded by software; the multiplier lives elsewhere
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prod_reg <= '0;
    end else if (wr & (paddr_in == P_LO_OFS)) begin
      prod_reg[DATA_W-1:0] <= pwdata_in;
    end else if (wr & (paddr_in == P_HI_OFS)) begin
      prod_reg[PROD_W-1:DATA_W] <= pwdata_in[PROD_HI_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flags_reg <= FLAGS_RST;
    end else if (exec) begin
      case (op)
        OP_NEG, OP_CNEG: begin
          if (neg_do) begin
            flags_reg[F_CARRY] <= neg_carry;
            flags_reg[F_ZERO] <= (neg_res == '0);
            flags_reg[F_OVF] <= neg_ovf;
            flags_reg[F_NEG] <= neg_ovf ^ neg_res[ACC_W-1];
          end
        end
        OP_MASK: begin
          flags_reg[F_ZERO] <= (mask_res == '0);
          flags_reg[F_SHOVF] <= 1'b0;
          flags_reg[F_NEG] <= mask_res[SG_W-1];
        end
        OP_BITCLR: begin
          // Selects beyond the flag word are ignored
          if (bit_select_field < 4'(FLAG_W)) begin
            flags_reg[bit_select_field] <= 1'b0;
          end
        end
        OP_RESTORE, OP_ROUND: begin
          if (mac_sel) begin
            flags_reg[F_GOV1] <= guard_ovf;
          end else begin
            flags_reg[F_GOV0] <= guard_ovf;
          end
          if (sticky_ovf) begin
            flags_reg[F_STICKY] <= 1'b1;
          end
        end
        default: ;
      endcase
    end else if (wr & (paddr_in == FLAGS_OFS)) begin
      flags_reg <= pwdata_in[FLAG_W-1:0];
    end
  end

  // Checks
  logic exec_d;
  logic [3:0] op_d;
  logic [1:0] acc_sel_d;
  logic mac_sel_d;
  logic [ACC_W-1:0] neg_src_d;
  logic [MAC_W-1:0] ma_src_d;
  logic [PROD_W-1:0] prod_d;
  logic [FLAG_W-1:0] flags_d;
  always_ff @(posedge sys_clk_in) begin
    exec_d <= exec & ~rst_in;
    op_d <= op;
    acc_sel_d <= acc_sel;
    mac_sel_d <= mac_sel;
    neg_src_d <= neg_src;
    ma_src_d <= ma_src;
    prod_d <= prod_reg;
    flags_d <= flags_reg;
  end

  neg_value_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & (op_d == OP_NEG) |-> acc_reg[acc_sel_d] == ACC_W'(-neg_src_d))
    else $error("negate result wrong");
  neg_flags_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & (op_d == OP_NEG) |->
      flags_reg[F_ZERO] == (neg_src_d == '0) &&
      flags_reg[F_CARRY] == (neg_src_d == '0) &&
      flags_reg[F_OVF] == (neg_src_d == ACC_MIN))
    else $error("negate flags wrong");
  neg_sign_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & (op_d == OP_NEG) |->
      flags_reg[F_NEG] == (flags_reg[F_OVF] ^ acc_reg[acc_sel_d][ACC_W-1]))
    else $error("negate sign flag wrong");
  cneg_skip_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & (op_d == OP_CNEG) & ~flags_d[F_COND] |->
      acc_reg[acc_sel_d] == neg_src_d && flags_reg == flags_d)
    else $error("conditional negate acted with flag clear");
  mask_upper_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec & (op == OP_MASK) |=>
      shift_guard_register_reg[SG_W-1:SG_LOW_W] == '0 &&
      (shift_guard_register_reg >> $past(imm)) == '0)
    else $error("mask left high bits set");
  mask_flags_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec & (op == OP_MASK) |=> !flags_reg[F_SHOVF] && !flags_reg[F_NEG] &&
      flags_reg[F_ZERO] == (shift_guard_register_reg == '0))
    else $error("mask flags wrong");
  bit_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec & (op == OP_BITCLR) & (bit_select_field < 4'(FLAG_W)) |=>
      !flags_reg[$past(bit_select_field)] &&
      ((flags_reg ^ $past(flags_reg)) &
       ~(FLAG_W'(1) << $past(bit_select_field))) == '0)
    else $error("bit clear touched other bits");
  restore_sum_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & (op_d == OP_RESTORE) |-> ma_reg[mac_sel_d] ==
      (flags_d[F_QSIGN] ?
        MAC_W'(ma_src_d + {{(MAC_W-PROD_W){prod_d[PROD_W-1]}}, prod_d} * 2) :
        ma_src_d))
    else $error("restore sum wrong");
  round_sum_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & (op_d == OP_ROUND) |->
      ma_reg[mac_sel_d] == MAC_W'(ma_src_d + ROUND_CONST))
    else $error("round sum wrong");
  guard_flag_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & ((op_d == OP_ROUND) | (op_d == OP_RESTORE)) |->
      flags_reg[F_GOV0 + 32'(mac_sel_d)] ==
      !($signed(ma_reg[mac_sel_d]) >= -(53'sd1 <<< GUARD_LSB) &&
        $signed(ma_reg[mac_sel_d]) < (53'sd1 <<< GUARD_LSB)))
    else $error("guard overflow flag wrong");
  sticky_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec_d & ((op_d == OP_ROUND) | (op_d == OP_RESTORE)) & flags_d[F_STICKY]
      |-> flags_reg[F_STICKY])
    else $error("sticky flag lost");
  idle_still_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec & (op == OP_IDLE) |=> $stable(flags_reg) &&
      $stable(shift_guard_register_reg) && $stable(ma_reg[0]) &&
      $stable(ma_reg[1]))
    else $error("idle op changed state");

  neg_ovf_c: cover property (@(posedge sys_clk_in)
    exec & (op == OP_NEG) & neg_ovf);
  cneg_run_c: cover property (@(posedge sys_clk_in)
    exec & (op == OP_CNEG) & flags_reg[F_COND]);
  round_guard_c: cover property (@(posedge sys_clk_in)
    exec & (op == OP_ROUND) & guard_ovf);
  restore_add_c: cover property (@(posedge sys_clk_in)
    exec & (op == OP_RESTORE) & flags_reg[F_QSIGN]);
endmodule

// [design/dsp_misc_pkg.sv]
// Purpose: Shared constants for the accumulator miscellaneous-ops block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Command word fields and flag bit positions live here
package dsp_misc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int ACC_W = 24;
  localparam int ACC_NUM = 4;
  localparam int MAC_W = 52;
  localparam int PROD_W = 48;
  localparam int SG_W = 24;
  localparam int SG_LOW_W = 16;
  localparam int FLAG_W = 10;
  localparam int MAC_HI_W = MAC_W - DATA_W;
  localparam int PROD_HI_W = PROD_W - DATA_W;
  localparam int GUARD_LSB = PROD_W - 1;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CMD_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] ACC0_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] SG_OFS = 12'h018;
  localparam logic [ADDR_W-1:0] MA0_LO_OFS = 12'h01C;
  localparam logic [ADDR_W-1:0] MA0_HI_OFS = 12'h020;
  localparam logic [ADDR_W-1:0] MA1_LO_OFS = 12'h024;
  localparam logic [ADDR_W-1:0] MA1_HI_OFS = 12'h028;
  localparam logic [ADDR_W-1:0] P_LO_OFS = 12'h02C;
  localparam logic [ADDR_W-1:0] P_HI_OFS = 12'h030;
  localparam logic [ADDR_W-1:0] ACC_STRIDE = 12'h004;

  // Opcodes in command word bits [3:0]
  localparam logic [3:0] OP_IDLE = 4'h0;
  localparam logic [3:0] OP_NEG = 4'h1;
  localparam logic [3:0] OP_CNEG = 4'h2;
  localparam logic [3:0] OP_MASK = 4'h3;
  localparam logic [3:0] OP_BITCLR = 4'h4;
  localparam logic [3:0] OP_RESTORE = 4'h5;
  localparam logic [3:0] OP_ROUND = 4'h6;

  // Command word field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ACC_LSB = 4;
  localparam int CMD_MAC_BIT = 6;
  localparam int CMD_IMM_LSB = 8;
  localparam int CMD_BS_LSB = 12;
  localparam int CMD_W = 16;

  // Flag word bit positions
  localparam int F_CARRY = 0;
  localparam int F_ZERO = 1;
  localparam int F_OVF = 2;
  localparam int F_NEG = 3;
  localparam int F_COND = 4;
  localparam int F_SHOVF = 5;
  localparam int F_QSIGN = 6;
  localparam int F_GOV0 = 7;
  localparam int F_GOV1 = 8;
  localparam int F_STICKY = 9;

  localparam logic [FLAG_W-1:0] FLAGS_RST = 10'h000;
  localparam logic [ACC_W-1:0] ACC_MIN = 24'h800000;
  localparam logic [MAC_W-1:0] ROUND_CONST = 52'h0000000800000;
  localparam logic [SG_LOW_W-1:0] SG_ONES = 16'hFFFF;
endpackage

// [tb/dsp_accumulator_misc_ops_tb_top.sv]
// Purpose: Self-checking bench for the accumulator misc ops
// Assumes: one command per APB write, results readable next transfer
// Notes: reads queue their expectation, a monitor compares at access
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module dsp_accumulator_misc_ops_tb_top;
  import dsp_misc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h3B7C39E5;
  logic [32:0] exp_q[$];
  string nm_q[$];
  // Popped once, so a mismatch report shows the same note
  logic [32:0] exp_v;
  string nm_v;
  always #5 sys_clk_in = ~sys_clk_in;
  dsp_host_model i_dsp_host_model (.sys_clk_in(sys_clk_in),
    .pready_in(pready), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
  dsp_misc_ops i_dsp_misc_ops (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    i_dsp_host_model.xfer(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [ADDR_W-1:0] a,
                    input logic [32:0] e);
    exp_q.push_back(e);
    nm_q.push_back(n);
    i_dsp_host_model.xfer(1'b0, a, 32'h00000000);
  endtask
  // Read data and error flag are both settled in the access cycle
  always @(posedge sys_clk_in) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] unexpected read exp=none got=%h", prdata);
      end else begin
        nm_v = nm_q.pop_front();
        exp_v = exp_q.pop_front();
        `CHK(nm_v, exp_v, {pslverr, prdata})
      end
    end
  end
  task automatic neg(input logic [1:0] k, input logic [23:0] a,
                     input logic [9:0] f, input logic [3:0] op);
    logic [23:0] r;
    logic [9:0] e;
    logic act;
    act = (op == OP_NEG) || f[F_COND];
    r = act ? ~a + 24'h000001 : a;
    e = f;
    if (act) begin
      e[F_CARRY] = (a == 24'h000000);
      e[F_ZERO] = (r == 24'h000000);
      e[F_OVF] = (a == ACC_MIN);
      e[F_NEG] = e[F_OVF] ^ r[23];
    end
    wr(ACC0_OFS + 12'(k * 4), {8'h00, a});
    wr(FLAGS_OFS, {22'h000000, f});
    wr(CMD_OFS, {24'h000000, 2'b00, k, op});
    rd("acc", ACC0_OFS + 12'(k * 4), {9'h000, r});
    rd("flags", FLAGS_OFS, {23'h000000, e});
  endtask
  task automatic wide(input logic [3:0] op, input logic mac,
                      input logic [51:0] ma, input logic [47:0] p,
                      input logic [9:0] f);
    logic [51:0] b, s;
    logic [9:0] e;
    logic [ADDR_W-1:0] base;
    base = MA0_LO_OFS + (mac ? 12'h008 : 12'h000);
    if (op == OP_ROUND) b = ROUND_CONST;
    else b = f[F_QSIGN] ? {{3{p[47]}}, p, 1'b0} : '0;
    s = ma + b;
    e = f;
    e[F_GOV0 + mac] = s[51:47] != 5'h00 && s[51:47] != 5'h1F;
    e[F_STICKY] = f[F_STICKY] | (ma[51] == b[51] && s[51] != ma[51]);
    wr(base, ma[31:0]);
    wr(base + 12'h004, {12'h000, ma[51:32]});
    wr(P_LO_OFS, p[31:0]);
    wr(P_HI_OFS, {16'h0000, p[47:32]});
    wr(FLAGS_OFS, {22'h000000, f});
    wr(CMD_OFS, {25'h0000000, mac, 2'b00, op});
    rd("ma_lo", base, {1'b0, s[31:0]});
    rd("ma_hi", base + 12'h004, {13'h0000, s[51:32]});
    rd("flags", FLAGS_OFS, {23'h000000, e});
  endtask
  initial begin
    #200000;
    err_total++;
    $display("[ERR] watchdog exp=done got=hang");
    summarize();
  end
  initial begin
    logic [23:0] tbl[4] = '{24'h000000, 24'h800000, 24'h000001, 24'h7FFFFF};
    logic [9:0] f;
    logic [23:0] a;
    logic [15:0] sg, m;
    logic [51:0] ma;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd("flags_rst", FLAGS_OFS, {1'b0, 32'h00000000});
    rd("unmapped", 12'h034, {1'b1, 32'h00000000});
    wr(12'h034, 32'hFFFFFFFF);
    rd("unmapped", 12'h034, {1'b1, 32'h00000000});
    $display("test reset_map done");
    for (int i = 0; i < 12; i++) begin
      f = 10'($random(seed));
      f[F_COND] = i[1];
      a = i < 4 ? tbl[i] : 24'($random(seed));
      neg(2'(i), a, f, OP_NEG);
      neg(2'(i + 1), a, f, OP_CNEG);
    end
    $display("test negate done");
    for (int i = 0; i < 16; i++) begin
      sg = i[0] ? 16'($random(seed)) : 16'hFFFF;
      f = 10'($random(seed));
      m = ~(16'hFFFF << i);
      wr(SG_OFS, {8'hFF, sg});
      wr(FLAGS_OFS, {22'h000000, f});
      wr(CMD_OFS, {16'h0000, 4'h0, 4'(i), 4'h0, OP_MASK});
      rd("sg", SG_OFS, {17'h00000, sg & m});
      f[F_ZERO] = (sg & m) == 16'h0000;
      f[F_SHOVF] = 1'b0;
      f[F_NEG] = 1'b0;
      rd("flags", FLAGS_OFS, {23'h000000, f});
    end
    $display("test mask done");
    for (int i = 0; i < 16; i++) begin
      f = i < 10 ? ~(10'h001 << i) : 10'h3FF;
      wr(FLAGS_OFS, {22'h000000, 10'h3FF});
      wr(CMD_OFS, {16'h0000, 4'(i), 8'h00, OP_BITCLR});
      rd("flags", FLAGS_OFS, {23'h000000, f});
    end
    $display("test bit_clear done");
    for (int i = 0; i < 12; i++) begin
      ma = {20'($random(seed)), 32'($random(seed))};
      if (i % 3 == 0) ma[51:32] = 20'h00000;
      if (i % 3 == 1) ma = 52'h7FFFFFFFFFFFF;
      f = 10'($random(seed));
      wide(i[0] ? OP_ROUND : OP_RESTORE, i[1], ma,
           {16'($random(seed)), 32'($random(seed))}, f);
    end
    $display("test wide done");
    for (int i = 0; i < 3; i++) begin
      f = 10'($random(seed));
      a = 24'($random(seed));
      wr(ACC0_OFS, {8'h00, a});
      wr(FLAGS_OFS, {22'h000000, f});
      wr(CMD_OFS, {24'h000000, 4'h0, i == 0 ? OP_IDLE : 4'(i * 7)});
      rd("acc", ACC0_OFS, {9'h000, a});
      rd("flags", FLAGS_OFS, {23'h000000, f});
      rd("cmd", CMD_OFS, {17'h00000, 12'h000, i == 0 ? OP_IDLE : 4'(i * 7)});
    end
    $display("test idle done");
    repeat (3) @(posedge sys_clk_in);
    summarize();
  end
endmodule

// [tb/dsp_host_model.sv]
// Purpose: APB master standing in for the host core
// Assumes: slave may stretch the access phase with pready low
// Notes: released lines show inverted values, never the last ones
`timescale 1ns/1ps
module dsp_host_model (
  input wire logic sys_clk_in,
  input wire logic pready_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [dsp_misc_pkg::ADDR_W-1:0] paddr_out,
  output logic [dsp_misc_pkg::DATA_W-1:0] pwdata_out
);
  import dsp_misc_pkg::*;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = '0;
    pwdata_out = '0;
  end
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge sys_clk_in);
    penable_out <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_in !== 1'b1) @(posedge sys_clk_in);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwrite_out <= ~w;
    paddr_out <= ~a;
    pwdata_out <= ~d;
    @(posedge sys_clk_in);
  endtask
endmodule
